// ===== rtu_slave_frame_handler.sv
`timescale 1ns/100ps
`include "rtu_params.svh"

// How it works
// - address 1..247 accepted only when equal to station number
// - own slave address is the station number setting input
// - reply address byte echoes the received address
// - second byte is the function code; accepted codes are executed
// - only 03, 06, 08, 10, 46 known; others get an error reply unless broadcast
// - normal reply repeats the received function code
// - error reply sends function code with bit 80 set
// - read holding registers never accepted by broadcast
// - single register write also executed on broadcast
// - multiple register write also executed on broadcast
// - access log and diagnostics refused on broadcast
// - data field handed on as-is, its meaning set by the function
// - two CRC bytes end each frame; each frame of 4 bytes or more with no error or overrun is checked
// - CRC low byte first, then high byte, both ways
// - each side computes its own CRC for what it sends
// - received CRC recomputed and compared; mismatch flagged
// - frames bounded by 3.5 character idle gaps
// - no reply on hardware, framing or CRC error
// - broadcast executed but never answered
// - error reply carries an error code in the data field
module rtu_slave_frame_handler #(
   parameter int GAP_CYCLES = `RTU_GAP_CYCLES,
   parameter int BUF_DEPTH = `RTU_BUF_DEPTH,
   parameter int FIFO_DEPTH = `RTU_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset,
   input wire rtu_pkg::byte_t station_number_setting,
   input wire logic rx_valid,
   input wire rtu_pkg::byte_t rx_data,
   input wire logic rx_error,
   output logic req_start_r,
   output rtu_pkg::byte_t req_func_r,
   output logic req_bcast_r,
   output logic req_byte_valid_r,
   output rtu_pkg::byte_t req_byte_r,
   output logic req_end_r,
   input wire logic resp_valid,
   input wire rtu_pkg::byte_t resp_data,
   input wire logic resp_last,
   input wire logic resp_error,
   output logic resp_ready_r,
   output logic tx_valid_r,
   output rtu_pkg::byte_t tx_data_r,
   input wire logic tx_ready,
   output logic crc_error_r,
   output logic frame_drop_r
);
   import rtu_pkg::*;

   localparam int LW = $clog2(BUF_DEPTH) + 1;
   localparam int GW = $clog2(GAP_CYCLES + 1);
   if (BUF_DEPTH < 8 || (1 << (LW - 1)) != BUF_DEPTH || GAP_CYCLES < 2) begin : g_bad_param
      $error("rtu_slave_frame_handler: unsupported parameter value");
   end
   fsm_state_t state_r, state_nxt;
   logic [GW-1:0] gap_cnt_r, gap_cnt_nxt;
   logic [LW-1:0] len_r, len_nxt, rd_idx_r, rd_idx_nxt, len_cur;
   byte_t addr_r, addr_nxt, func_r, func_nxt, b1_r, b1_nxt, b2_r, b2_nxt;
   logic [15:0] crc_rx_r, crc_rx_nxt, crc_d1_r, crc_d1_nxt, crc_d2_r, crc_d2_nxt;
   logic [15:0] crc_tx_r, crc_tx_nxt, crc_rx_upd, crc_tx_upd, crc_seed;
   logic bad_r, bad_nxt, loc_err_r, loc_err_nxt, bcast_r, bcast_nxt;
   logic req_start_nxt, req_bcast_nxt, req_byte_valid_nxt, req_end_nxt;
   byte_t req_func_nxt, req_byte_nxt, tx_data_nxt, tx_byte;
   logic resp_ready_nxt, tx_valid_nxt, crc_error_nxt, frame_drop_nxt;
   logic rx_ev, rx_take, gap_done, crc_ok, addr_ok, take, tx_push;
   byte_t rx_buf [BUF_DEPTH];
   byte_stream_if #(.W(8)) fifo_in ();
   byte_stream_if #(.W(8)) fifo_out ();

   // ****************************************
   // check value and reply buffer
   // ****************************************
   rtu_crc16 u_crc_rx (.crc_in(crc_seed), .data(rx_data), .crc_out(crc_rx_upd));
   rtu_crc16 u_crc_tx (.crc_in(crc_tx_r), .data(tx_byte), .crc_out(crc_tx_upd));
   rtu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(clk),
      .reset(reset),
      .wr(fifo_in),
      .rd(fifo_out)
   );
   assign rx_ev = rx_valid || rx_error;
   // a frame may open in the first idle cycle, before stale state is cleared
   assign crc_seed = (state_r == S_IDLE) ? `RTU_CRC_INIT : crc_rx_r;
   assign len_cur = (state_r == S_IDLE) ? '0 : len_r;
   assign rx_take = rx_valid && (state_r == S_IDLE || state_r == S_RECV);
   assign gap_done = gap_cnt_r == GW'(GAP_CYCLES);
   assign crc_ok = crc_d2_r == {b1_r, b2_r};
   assign addr_ok = addr_r == `RTU_BCAST_ADDR ||
                    (addr_r == station_number_setting && addr_r <= `RTU_MAX_STATION);
   assign take = resp_ready_r && resp_valid;
   assign fifo_in.valid = tx_push;
   assign fifo_in.data = tx_byte;
   assign fifo_out.ready = !tx_valid_r || tx_ready;
   // ****************************************
   // reply byte selection
   // ****************************************
   always_comb begin
      tx_push = 1'b0;
      tx_byte = addr_r;
      case (state_r)
         S_TXADR: tx_push = 1'b1;
         S_TXFUNC: begin
            // wait for the first answer byte to learn normal or error
            tx_push = loc_err_r || resp_valid;
            tx_byte = (loc_err_r || resp_error) ? (func_r | `RTU_ERR_FLAG) : func_r;
         end
         S_TXDATA: begin
            tx_push = loc_err_r || take;
            tx_byte = loc_err_r ? `RTU_EXC_ILLEGAL_FUNC : resp_data;
         end
         S_TXCRCL: begin
            tx_push = 1'b1;
            tx_byte = crc_tx_r[7:0];
         end
         S_TXCRCH: begin
            tx_push = 1'b1;
            tx_byte = crc_tx_r[15:8];
         end
         default: tx_push = 1'b0;
      endcase
   end
   // ****************************************
   // frame sequencing
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      gap_cnt_nxt = rx_ev ? '0 : (gap_done ? gap_cnt_r : gap_cnt_r + 1'b1);
      len_nxt = len_r;
      rd_idx_nxt = rd_idx_r;
      addr_nxt = addr_r;
      func_nxt = func_r;
      b1_nxt = b1_r;
      b2_nxt = b2_r;
      crc_rx_nxt = crc_rx_r;
      crc_d1_nxt = crc_d1_r;
      crc_d2_nxt = crc_d2_r;
      crc_tx_nxt = crc_tx_r;
      bad_nxt = bad_r;
      loc_err_nxt = loc_err_r;
      bcast_nxt = bcast_r;
      req_start_nxt = 1'b0;
      req_func_nxt = req_func_r;
      req_bcast_nxt = req_bcast_r;
      req_byte_valid_nxt = 1'b0;
      req_byte_nxt = req_byte_r;
      req_end_nxt = 1'b0;
      crc_error_nxt = 1'b0;
      frame_drop_nxt = 1'b0;
      resp_ready_nxt = state_r == S_TXDATA && !loc_err_r && !take && fifo_in.ready;
      tx_valid_nxt = tx_valid_r;
      tx_data_nxt = tx_data_r;
      if (fifo_out.ready) begin
         tx_valid_nxt = fifo_out.valid;
         tx_data_nxt = fifo_out.valid ? fifo_out.data : tx_data_r;
      end
      if (state_r == S_IDLE) begin
         len_nxt = '0;
         bad_nxt = 1'b0;
      end
      if (rx_take) begin
         crc_d2_nxt = crc_d1_r;
         crc_d1_nxt = crc_seed;
         crc_rx_nxt = crc_rx_upd;
         b2_nxt = b1_r;
         b1_nxt = rx_data;
         if (len_cur == '0) addr_nxt = rx_data;
         if (len_cur == LW'(1)) func_nxt = rx_data;
         if (len_cur == LW'(BUF_DEPTH)) begin
            bad_nxt = 1'b1;
         end else begin
            len_nxt = len_cur + 1'b1;
         end
      end
      if (rx_error && (state_r == S_IDLE || state_r == S_RECV)) bad_nxt = 1'b1;
      case (state_r)
         S_HUNT: if (gap_done) state_nxt = S_IDLE;
         S_IDLE: if (rx_ev) state_nxt = S_RECV;
         S_RECV: if (gap_done) state_nxt = S_CHECK;
         S_CHECK: begin
            state_nxt = S_IDLE;
            crc_tx_nxt = `RTU_CRC_INIT;
            rd_idx_nxt = LW'(2);
            bcast_nxt = addr_r == `RTU_BCAST_ADDR;
            loc_err_nxt = 1'b0;
            req_func_nxt = func_r;
            req_bcast_nxt = addr_r == `RTU_BCAST_ADDR;
            if (bad_r || len_r < LW'(4)) begin
               frame_drop_nxt = 1'b1;
            end else if (!crc_ok) begin
               crc_error_nxt = 1'b1;
            end else if (!addr_ok) begin
               state_nxt = S_IDLE;
            end else if (addr_r == `RTU_BCAST_ADDR) begin
               if (func_known(func_r) && func_bcast_ok(func_r)) begin
                  req_start_nxt = 1'b1;
                  state_nxt = S_DELIV;
               end
            end else if (func_known(func_r)) begin
               req_start_nxt = 1'b1;
               state_nxt = S_DELIV;
            end else begin
               loc_err_nxt = 1'b1;
               state_nxt = S_TXADR;
            end
         end
         S_DELIV: begin
            if (rd_idx_r < len_r - LW'(2)) begin
               req_byte_valid_nxt = 1'b1;
               req_byte_nxt = rx_buf[rd_idx_r[LW-2:0]];
               rd_idx_nxt = rd_idx_r + 1'b1;
            end else begin
               req_end_nxt = 1'b1;
               state_nxt = bcast_r ? S_IDLE : S_TXADR;
            end
         end
         S_TXADR, S_TXFUNC: begin
            if (tx_push && fifo_in.ready) begin
               crc_tx_nxt = crc_tx_upd;
               state_nxt = state_r == S_TXADR ? S_TXFUNC : S_TXDATA;
            end
         end
         S_TXDATA: begin
            if (tx_push && fifo_in.ready) begin
               crc_tx_nxt = crc_tx_upd;
               if (loc_err_r || resp_last) state_nxt = S_TXCRCL;
            end
         end
         S_TXCRCL: if (fifo_in.ready) state_nxt = S_TXCRCH;
         S_TXCRCH: if (fifo_in.ready) state_nxt = S_HUNT;
         default: state_nxt = S_HUNT;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rx_take && len_cur < LW'(BUF_DEPTH)) rx_buf[len_cur[LW-2:0]] <= rx_data;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= S_HUNT;
         gap_cnt_r <= '0;
         len_r <= '0;
         rd_idx_r <= '0;
         addr_r <= 8'h00;
         func_r <= 8'h00;
         b1_r <= 8'h00;
         b2_r <= 8'h00;
         crc_rx_r <= `RTU_CRC_INIT;
         crc_d1_r <= `RTU_CRC_INIT;
         crc_d2_r <= `RTU_CRC_INIT;
         crc_tx_r <= `RTU_CRC_INIT;
         bad_r <= 1'b0;
         loc_err_r <= 1'b0;
         bcast_r <= 1'b0;
         req_start_r <= 1'b0;
         req_func_r <= 8'h00;
         req_bcast_r <= 1'b0;
         req_byte_valid_r <= 1'b0;
         req_byte_r <= 8'h00;
         req_end_r <= 1'b0;
         resp_ready_r <= 1'b0;
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
         crc_error_r <= 1'b0;
         frame_drop_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         gap_cnt_r <= gap_cnt_nxt;
         len_r <= len_nxt;
         rd_idx_r <= rd_idx_nxt;
         addr_r <= addr_nxt;
         func_r <= func_nxt;
         b1_r <= b1_nxt;
         b2_r <= b2_nxt;
         crc_rx_r <= crc_rx_nxt;
         crc_d1_r <= crc_d1_nxt;
         crc_d2_r <= crc_d2_nxt;
         crc_tx_r <= crc_tx_nxt;
         bad_r <= bad_nxt;
         loc_err_r <= loc_err_nxt;
         bcast_r <= bcast_nxt;
         req_start_r <= req_start_nxt;
         req_func_r <= req_func_nxt;
         req_bcast_r <= req_bcast_nxt;
         req_byte_valid_r <= req_byte_valid_nxt;
         req_byte_r <= req_byte_nxt;
         req_end_r <= req_end_nxt;
         resp_ready_r <= resp_ready_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_data_r <= tx_data_nxt;
         crc_error_r <= crc_error_nxt;
         frame_drop_r <= frame_drop_nxt;
      end
   end
   // ****************************************
   // checks
   // ****************************************
   a_bcast_no_reply: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_TXADR) |-> !bcast_r)
      else $error("reply started for a broadcast frame");
   a_addr_echo: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_TXADR && fifo_in.valid) |-> fifo_in.data == addr_r)
      else $error("reply address differs from query address");
   a_func_normal: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_TXFUNC && tx_push && !loc_err_r && !resp_error) |-> tx_byte == func_r)
      else $error("normal reply function code altered");
   a_func_error: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_TXFUNC && tx_push && loc_err_r) |-> tx_byte == (func_r | 8'h80))
      else $error("error reply lacks the top bit");
   a_known_only: assert property (@(posedge clk) disable iff (reset)
      req_start_r |-> func_known(req_func_r) ##1 !req_start_r)
      else $error("unknown function dispatched");
   a_bcast_perm: assert property (@(posedge clk) disable iff (reset)
      (req_start_r && req_bcast_r) |-> func_bcast_ok(req_func_r))
      else $error("function not allowed by broadcast dispatched");
   a_crc_gate: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_CHECK && !crc_ok && !bad_r && len_r >= LW'(4))
      |=> crc_error_r && !req_start_r && state_r == S_IDLE ##1 state_r != S_TXADR)
      else $error("bad check value not refused");
   a_station_match: assert property (@(posedge clk) disable iff (reset)
      (req_start_r && !req_bcast_r) |-> addr_r == $past(station_number_setting)
      && addr_r <= 8'hf7)
      else $error("frame for another station dispatched");
   a_crc_order: assert property (@(posedge clk) disable iff (reset)
      (state_r == S_TXCRCL && fifo_in.ready)
      |=> state_r == S_TXCRCH && tx_byte == $past(crc_tx_r[15:8]))
      else $error("check bytes out of order");
   a_gap_before_check: assert property (@(posedge clk) disable iff (reset)
      $rose(state_r == S_CHECK) |-> !$past(rx_valid) && !$past(rx_valid, 2))
      else $error("frame closed without an idle gap");
endmodule : rtu_slave_frame_handler

// ===== rtu_params.svh
`ifndef RTU_PARAMS_SVH
`define RTU_PARAMS_SVH

// ****************************************
// address field
// ****************************************
`define RTU_BCAST_ADDR 8'h00
`define RTU_MAX_STATION 8'hf7

// ****************************************
// function field
// ****************************************
`define RTU_FN_READ_HOLD 8'h03
`define RTU_FN_WRITE_ONE 8'h06
`define RTU_FN_DIAG 8'h08
`define RTU_FN_WRITE_MULTI 8'h10
`define RTU_FN_ACCESS_LOG 8'h46
`define RTU_ERR_FLAG 8'h80
`define RTU_EXC_ILLEGAL_FUNC 8'h01

// ****************************************
// check field
// ****************************************
`define RTU_CRC_INIT 16'hffff
`define RTU_CRC_POLY 16'ha001

// ****************************************
// timing and sizes
// ****************************************
`define RTU_CLK_NS 40
// one 11-bit character at 19200 bit/s, in ns
`define RTU_CHAR_NS 572917
// idle gap in tenths of a character: 3.5 characters
`define RTU_GAP_TENTHS 35
`define RTU_GAP_CYCLES ((`RTU_CHAR_NS * `RTU_GAP_TENTHS + 10 * `RTU_CLK_NS - 1) / (10 * `RTU_CLK_NS))
`define RTU_BUF_DEPTH 256
`define RTU_FIFO_DEPTH 8

`endif

// ===== rtu_pkg.sv
`include "rtu_params.svh"

package rtu_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic [9:0] {
      S_HUNT = 10'h001,
      S_IDLE = 10'h002,
      S_RECV = 10'h004,
      S_CHECK = 10'h008,
      S_DELIV = 10'h010,
      S_TXADR = 10'h020,
      S_TXFUNC = 10'h040,
      S_TXDATA = 10'h080,
      S_TXCRCL = 10'h100,
      S_TXCRCH = 10'h200
   } fsm_state_t;

   function automatic logic func_known(input byte_t f);
      return f == `RTU_FN_READ_HOLD || f == `RTU_FN_WRITE_ONE || f == `RTU_FN_DIAG ||
             f == `RTU_FN_WRITE_MULTI || f == `RTU_FN_ACCESS_LOG;
   endfunction : func_known

   function automatic logic func_bcast_ok(input byte_t f);
      return f == `RTU_FN_WRITE_ONE || f == `RTU_FN_WRITE_MULTI;
   endfunction : func_bcast_ok

endpackage : rtu_pkg

// ===== byte_stream_if.sv
`timescale 1ns/100ps

interface byte_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ===== rtu_crc16.sv
`timescale 1ns/100ps
`include "rtu_params.svh"

module rtu_crc16 (
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data,
   output logic [15:0] crc_out
);
   logic [15:0] c;

   // reflected update, one byte, lsb first
   always_comb begin
      c = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `RTU_CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule : rtu_crc16

// ===== rtu_fifo.sv
`timescale 1ns/100ps

module rtu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   byte_stream_if.snk wr,
   byte_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("rtu_fifo: depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign wr.ready = cnt_r != (AW + 1)'(DEPTH);
   assign rd.valid = cnt_r != '0;
   assign rd.data = mem[rp_r];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= wr.data;
      end
   end
endmodule : rtu_fifo

// ===== rtu_master_model.sv
`timescale 1ns/100ps

// ****************************************
// master controller on the far side of the link
// ****************************************
module rtu_master_model (
   input wire logic clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_error,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got_q[$];
   logic slow = 1'b0;
   logic [1:0] stall_r = 2'h0;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_error = 1'b0;
      tx_ready = 1'b0;
   end

   // crc-16, init ffff, reflected poly a001
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction : crc

   // query: address, function, data, then own check value, low byte first
   task automatic send(input logic [7:0] q[$], input logic bad, input int err_at);
      logic [15:0] c;
      c = crc(q);
      if (bad) begin
         c = c ^ 16'h0001;
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data <= q[i];
         rx_error <= (i == err_at);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      // released line does not keep the last byte
      rx_data <= ~q[q.size()-1];
   endtask : send

   // reply capture, optionally stalling three cycles in four
   always @(posedge clk) begin
      stall_r <= stall_r + 2'h1;
      tx_ready <= !slow || (stall_r == 2'h0);
      if (tx_valid && tx_ready) begin
         got_q.push_back(tx_data);
      end
   end
endmodule : rtu_master_model

// ===== rtu_slave_frame_handler_test.sv
`timescale 1ns/100ps

module rtu_slave_frame_handler_test;
   localparam int GAP = 20;
   localparam int LIMIT = 20000;
   logic clk;
   logic reset;
   logic [7:0] station;
   logic resp_valid;
   logic [7:0] resp_data;
   logic resp_last;
   logic resp_error;
   logic rx_valid;
   logic [7:0] rx_data;
   logic rx_error;
   logic tx_ready;
   logic resp_ready_r;
   logic tx_valid_r;
   logic [7:0] tx_data_r;
   logic req_start_r;
   logic [7:0] req_func_r;
   logic req_bcast_r;
   logic req_byte_valid_r;
   logic [7:0] req_byte_r;
   logic req_end_r;
   logic crc_error_r;
   logic frame_drop_r;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int n_start;
   int n_end;
   int n_crc;
   int n_drop;
   logic [7:0] s_func;
   logic got_bcast;
   logic [7:0] reqq[$];

   rtu_slave_frame_handler #(.GAP_CYCLES(GAP)) dut (
      .clk(clk), .reset(reset), .station_number_setting(station),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
      .req_start_r(req_start_r), .req_func_r(req_func_r), .req_bcast_r(req_bcast_r),
      .req_byte_valid_r(req_byte_valid_r), .req_byte_r(req_byte_r), .req_end_r(req_end_r),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
      .resp_error(resp_error), .resp_ready_r(resp_ready_r), .tx_valid_r(tx_valid_r),
      .tx_data_r(tx_data_r), .tx_ready(tx_ready), .crc_error_r(crc_error_r),
      .frame_drop_r(frame_drop_r)
   );

   rtu_master_model m (
      .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
      .tx_valid(tx_valid_r), .tx_data(tx_data_r), .tx_ready(tx_ready)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // result capture and hang guard
   // ****************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (req_start_r === 1'b1) begin
         n_start++;
         s_func = req_func_r;
         got_bcast = req_bcast_r;
      end
      if (req_byte_valid_r === 1'b1) reqq.push_back(req_byte_r);
      if (req_end_r === 1'b1) n_end++;
      if (crc_error_r === 1'b1) n_crc++;
      if (frame_drop_r === 1'b1) n_drop++;
      if (cyc == LIMIT) begin
         num_errors++;
         end_sim();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // idle gap first, then one query and time for its delivery
   task automatic frame(input logic [7:0] q[$], input logic bad, input int err_at);
      repeat (2 * GAP) @(posedge clk);
      n_start = 0;
      n_end = 0;
      n_crc = 0;
      n_drop = 0;
      reqq.delete();
      m.got_q.delete();
      m.send(q, bad, err_at);
      repeat (GAP + q.size() + 8) @(posedge clk);
   endtask : frame

   task automatic reply(input logic [7:0] d[$], input logic err);
      int k;
      foreach (d[i]) begin
         resp_valid <= 1'b1;
         resp_data <= d[i];
         resp_last <= (i == d.size() - 1);
         resp_error <= err;
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (resp_ready_r !== 1'b1 && k < 50);
         chk("resp taken", 1, resp_ready_r);
      end
      resp_valid <= 1'b0;
      resp_last <= 1'b0;
      resp_error <= 1'b0;
   endtask : reply

   task automatic expect_tx(input logic [7:0] q[$]);
      logic [15:0] c;
      int k;
      c = m.crc(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      k = 0;
      while (m.got_q.size() < q.size() && k < 300) begin
         @(posedge clk);
         k++;
      end
      repeat (10) @(posedge clk);
      chk("tx count", q.size(), m.got_q.size());
      foreach (q[i]) if (i < m.got_q.size()) chk("tx byte", q[i], m.got_q[i]);
   endtask : expect_tx

   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_write();
      station <= 8'h05;
      frame({8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70}, 1'b0, -1);
      chk("start", 1, n_start);
      chk("func", 8'h06, s_func);
      chk("bcast", 0, got_bcast);
      chk("data count", 4, reqq.size());
      chk("data 0", 8'h00, reqq[0]);
      chk("data 3", 8'h70, reqq[3]);
      chk("end", 1, n_end);
      m.slow = 1'b1;
      reply({8'h00, 8'h0d, 8'h17, 8'h70}, 1'b0);
      expect_tx({8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70});
      m.slow = 1'b0;
   endtask : s_write

   task automatic s_bcast();
      logic [7:0] codes[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
      logic ok;
      foreach (codes[i]) begin
         ok = (codes[i] == 8'h06) || (codes[i] == 8'h10);
         frame({8'h00, codes[i], 8'h00, 8'h01}, 1'b0, -1);
         repeat (GAP) @(posedge clk);
         chk("bcast start", ok, n_start);
         if (ok) chk("bcast flag", 1, got_bcast);
         chk("bcast tx", 0, m.got_q.size());
      end
   endtask : s_bcast

   task automatic s_unknown();
      frame({8'h05, 8'h2b, 8'h00, 8'h01}, 1'b0, -1);
      chk("unk start", 0, n_start);
      expect_tx({8'h05, 8'hab, 8'h01});
   endtask : s_unknown

   task automatic s_err_reply();
      frame({8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, -1);
      chk("read start", 1, n_start);
      chk("read func", 8'h03, s_func);
      reply({8'h02}, 1'b1);
      expect_tx({8'h05, 8'h83, 8'h02});
   endtask : s_err_reply

   task automatic s_spoiled();
      frame({8'h05, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 1'b1, -1);
      repeat (GAP) @(posedge clk);
      chk("crc flag", 1, n_crc);
      chk("crc start", 0, n_start);
      chk("crc tx", 0, m.got_q.size());
      frame({8'h05, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 1'b0, 3);
      repeat (GAP) @(posedge clk);
      chk("drop flag", 1, n_drop);
      chk("drop start", 0, n_start);
      chk("drop tx", 0, m.got_q.size());
   endtask : s_spoiled

   task automatic s_foreign();
      logic [7:0] adr[2] = '{8'h06, 8'hf8};
      station <= 8'hf8;
      foreach (adr[i]) begin
         frame({adr[i], 8'h08, 8'h00, 8'h00}, 1'b0, -1);
         repeat (GAP) @(posedge clk);
         chk("foreign start", 0, n_start);
         chk("foreign tx", 0, m.got_q.size());
      end
      station <= 8'h06;
      frame({8'h06, 8'h08, 8'h00, 8'h00}, 1'b0, -1);
      chk("new station", 1, n_start);
      reply({8'h00, 8'h00}, 1'b0);
      expect_tx({8'h06, 8'h08, 8'h00, 8'h00});
   endtask : s_foreign

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset = 1'b1;
      station = 8'h05;
      resp_valid = 1'b0;
      resp_data = 8'h00;
      resp_last = 1'b0;
      resp_error = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      s_write();
      s_bcast();
      s_unknown();
      s_err_reply();
      s_spoiled();
      s_foreign();
      end_sim();
   end
endmodule : rtu_slave_frame_handler_test
